// *** torque_arbiter_cfg.svh ***
`ifndef TORQUE_ARBITER_CFG_SVH
`define TORQUE_ARBITER_CFG_SVH

// ****************************************
// Register offsets
// ****************************************
`define CFG_OFS_MODE 8'h00
`define CFG_OFS_PRI_REF 8'h04
`define CFG_OFS_PRI_DIV 8'h08
`define CFG_OFS_SEC_REF 8'h0C
`define CFG_OFS_SEC_MULT 8'h10
`define CFG_OFS_TRIM 8'h14
`define CFG_OFS_SETPT 8'h18
`define CFG_OFS_DWELL 8'h1C
`define CFG_OFS_STATUS 8'h20
`define CFG_OFS_CMD 8'h24
`define CFG_OFS_TREF 8'h28

// ****************************************
// Reset values and fields
// ****************************************
`define CFG_RST_MODE 4'h1
`define CFG_RST_DIV 16'h0001
`define CFG_RST_MULT 16'h0001
`define CFG_RST_SETPT 16'h0000
`define CFG_RST_DWELL 16'h0000
`define STAT_BIT_SPEED 0
`define STAT_BIT_FORCED 1

// ****************************************
// Mode codes
// ****************************************
`define MODE_ZERO 4'h0
`define MODE_SPEED 4'h1
`define MODE_TORQUE 4'h2
`define MODE_MIN 4'h3
`define MODE_MAX 4'h4
`define MODE_SUM 4'h5
`define MODE_ABS_MIN 4'h6
`define MODE_LIM_MIN 4'h7
`define MODE_LIM_MAX 4'h8

`endif

// *** torque_arbiter_pkg.sv ***
package torque_arbiter_pkg;
   // Limited-speed torque control state
   typedef enum logic [0:0] {ST_TORQUE, ST_SPEED} speed_limited_torque_mode_state_t;
   // Register selected by a bus address
   typedef enum logic [3:0] {
      SEL_MODE, SEL_PRI_REF, SEL_PRI_DIV, SEL_SEC_REF, SEL_SEC_MULT,
      SEL_TRIM, SEL_SETPT, SEL_DWELL, SEL_STATUS, SEL_CMD, SEL_TREF,
      SEL_NONE
   } reg_sel_t;
endpackage

// *** torque_ref_scaler.sv ***
`timescale 1ns/10ps

module torque_ref_scaler #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic signed [W-1:0] primaryRef,
   input wire logic [W-1:0] primaryDiv,
   input wire logic signed [W-1:0] secondaryRef,
   input wire logic signed [W-1:0] secondaryMult,
   input wire logic signed [W-1:0] trim,
   output logic signed [W-1:0] torqueRef
);
   localparam int SW = 2*W+2;
   logic signed [W:0] divSafe;
   logic signed [W:0] quotient;
   logic signed [2*W-1:0] product;
   logic signed [SW-1:0] total;
   logic signed [W-1:0] torqueRef_reg;
   logic signed [W-1:0] torqueRef_next;

   // A zero divider is taken as one rather than faulting the loop
   always_comb begin
      divSafe = $signed({1'b0, primaryDiv});
      if (primaryDiv == '0) begin
         divSafe = (W+1)'(1);
      end
      quotient = $signed({primaryRef[W-1], primaryRef}) / divSafe;
      product = secondaryRef * secondaryMult;
      total = SW'(quotient) + SW'(product) + SW'(trim);
      // Saturate instead of wrapping, a wrap would flip torque sign
      if (total[SW-1:W-1] == '0 || total[SW-1:W-1] == '1) begin
         torqueRef_next = total[W-1:0];
      end else if (total[SW-1]) begin
         torqueRef_next = {1'b1, {(W-1){1'b0}}};
      end else begin
         torqueRef_next = {1'b0, {(W-1){1'b1}}};
      end
   end

   // One sample of latency on the scaled reference
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         torqueRef_reg <= '0;
      end else begin
         torqueRef_reg <= torqueRef_next;
      end
   end

   assign torqueRef = torqueRef_reg;

   AST_SCALE_ZERO_DIV: assert property (@(posedge clk)
      disable iff (!rstn)
      primaryDiv == '0 && secondaryMult == '0 && trim == '0
      |=> torqueRef == $past(primaryRef))
      else $error("Zero divider not treated as one");
endmodule

// *** torque_speed_mode_arbiter.sv ***
`timescale 1ns/10ps
`include "torque_arbiter_cfg.svh"

module torque_speed_mode_arbiter
   import torque_arbiter_pkg::*;
#(
   parameter int W = 16,
   parameter int AW = 8
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [AW-1:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic signed [W-1:0] speedRef,
   input wire logic signed [W-1:0] speedFbk,
   input wire logic signed [W-1:0] spdRegTorque,
   output logic signed [W-1:0] torqueCmd,
   output logic preloadStrobe,
   output logic signed [W-1:0] preloadValue,
   output logic speedActive,
   output logic forcedSpeed
);
   // ****************************************
   // Declarations
   // ****************************************
   logic [3:0] modeSel_reg;
   logic signed [W-1:0] primaryRef_reg;
   logic [W-1:0] primaryDiv_reg;
   logic signed [W-1:0] secondaryRef_reg;
   logic signed [W-1:0] secondaryMult_reg;
   logic signed [W-1:0] trim_reg;
   logic signed [W-1:0] errSetpt_reg;
   logic [W-1:0] dwell_reg;
   logic [31:0] prdata_reg;
   logic [31:0] readData;
   reg_sel_t sel;
   logic wrEn;
   logic signed [W-1:0] tref;
   logic signed [W:0] speedErr;
   logic signed [W:0] spdExt;
   logic signed [W:0] trefExt;
   logic signed [W:0] setptExt;
   logic slatMin;
   logic slatMax;
   logic slatOn;
   logic setCond;
   logic relCond;
   logic toSpeed;
   logic toTorque;
   speed_limited_torque_mode_state_t state_reg;
   speed_limited_torque_mode_state_t state_next;
   logic forced_reg;
   logic forced_next;
   logic [W-1:0] dwellCnt_reg;
   logic dwellDone;
   logic signed [W-1:0] torqueCmd_reg;
   logic signed [W-1:0] cmdNext;
   logic signed [W:0] sumFull;
   logic signed [W:0] absSpd;
   logic signed [W:0] absTref;
   logic preloadStrobe_reg;
   logic signed [W-1:0] preloadValue_reg;

   // ****************************************
   // Helper functions
   // ****************************************
   // Address decode, shared by write, read and error paths
   function automatic reg_sel_t regSel(input logic [AW-1:0] a);
      reg_sel_t s;
      s = SEL_NONE;
      case (a)
         AW'(`CFG_OFS_MODE): s = SEL_MODE;
         AW'(`CFG_OFS_PRI_REF): s = SEL_PRI_REF;
         AW'(`CFG_OFS_PRI_DIV): s = SEL_PRI_DIV;
         AW'(`CFG_OFS_SEC_REF): s = SEL_SEC_REF;
         AW'(`CFG_OFS_SEC_MULT): s = SEL_SEC_MULT;
         AW'(`CFG_OFS_TRIM): s = SEL_TRIM;
         AW'(`CFG_OFS_SETPT): s = SEL_SETPT;
         AW'(`CFG_OFS_DWELL): s = SEL_DWELL;
         AW'(`CFG_OFS_STATUS): s = SEL_STATUS;
         AW'(`CFG_OFS_CMD): s = SEL_CMD;
         AW'(`CFG_OFS_TREF): s = SEL_TREF;
         default: s = SEL_NONE;
      endcase
      return s;
   endfunction

   // Clamp a one-bit-wider sum back into the torque range
   function automatic logic signed [W-1:0] satW(
      input logic signed [W:0] v
   );
      logic signed [W-1:0] r;
      r = v[W-1:0];
      if (v[W] != v[W-1]) begin
         r = v[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
      end
      return r;
   endfunction

   // ****************************************
   // APB slave
   // ****************************************
   // Zero wait states; unmapped or read-only writes flag an error
   assign sel = regSel(paddr);
   assign wrEn = psel && penable && pwrite && sel < SEL_STATUS;
   assign pready = 1'b1;
   assign pslverr = psel && penable
      && (sel == SEL_NONE || (pwrite && sel >= SEL_STATUS));
   assign prdata = prdata_reg;

   // Configuration registers
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         modeSel_reg <= `CFG_RST_MODE;
         primaryRef_reg <= '0;
         primaryDiv_reg <= `CFG_RST_DIV;
         secondaryRef_reg <= '0;
         secondaryMult_reg <= `CFG_RST_MULT;
         trim_reg <= '0;
         errSetpt_reg <= `CFG_RST_SETPT;
         dwell_reg <= `CFG_RST_DWELL;
      end else if (wrEn) begin
         case (sel)
            SEL_MODE: modeSel_reg <= pwdata[3:0];
            SEL_PRI_REF: primaryRef_reg <= pwdata[W-1:0];
            SEL_PRI_DIV: primaryDiv_reg <= pwdata[W-1:0];
            SEL_SEC_REF: secondaryRef_reg <= pwdata[W-1:0];
            SEL_SEC_MULT: secondaryMult_reg <= pwdata[W-1:0];
            SEL_TRIM: trim_reg <= pwdata[W-1:0];
            SEL_SETPT: errSetpt_reg <= pwdata[W-1:0];
            SEL_DWELL: dwell_reg <= pwdata[W-1:0];
            default: ;
         endcase
      end
   end

   // Read mux; narrow fields sit low, upper bits read zero
   always_comb begin
      readData = '0;
      case (sel)
         SEL_MODE: readData[3:0] = modeSel_reg;
         SEL_PRI_REF: readData[W-1:0] = primaryRef_reg;
         SEL_PRI_DIV: readData[W-1:0] = primaryDiv_reg;
         SEL_SEC_REF: readData[W-1:0] = secondaryRef_reg;
         SEL_SEC_MULT: readData[W-1:0] = secondaryMult_reg;
         SEL_TRIM: readData[W-1:0] = trim_reg;
         SEL_SETPT: readData[W-1:0] = errSetpt_reg;
         SEL_DWELL: readData[W-1:0] = dwell_reg;
         SEL_STATUS: begin
            readData[`STAT_BIT_SPEED] = state_reg == ST_SPEED;
            readData[`STAT_BIT_FORCED] = forced_reg;
         end
         SEL_CMD: readData[W-1:0] = torqueCmd_reg;
         SEL_TREF: readData[W-1:0] = tref;
         default: readData = '0;
      endcase
   end

   // Read data captured in the setup cycle, stable in access
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         prdata_reg <= '0;
      end else if (psel && !penable) begin
         prdata_reg <= readData;
      end
   end

   // ****************************************
   // Torque reference scaling
   // ****************************************
   torque_ref_scaler #(
      .W(W)
   ) u_torque_ref_scaler (
      .clk(clk),
      .rstn(rstn),
      .primaryRef(primaryRef_reg),
      .primaryDiv(primaryDiv_reg),
      .secondaryRef(secondaryRef_reg),
      .secondaryMult(secondaryMult_reg),
      .trim(trim_reg),
      .torqueRef(tref)
   );

   // ****************************************
   // Limited-speed torque conditions
   // ****************************************
   // Error is reference minus feedback, one bit wider to avoid wrap
   assign spdExt = (W+1)'(spdRegTorque);
   assign trefExt = (W+1)'(tref);
   assign setptExt = (W+1)'(errSetpt_reg);
   assign speedErr = (W+1)'(speedRef) - (W+1)'(speedFbk);
   assign slatMin = modeSel_reg == `MODE_LIM_MIN;
   assign slatMax = modeSel_reg == `MODE_LIM_MAX;
   assign slatOn = slatMin || slatMax;

   // Forcing and release tests swap direction between min and max
   always_comb begin
      setCond = 1'b0;
      relCond = 1'b0;
      toSpeed = 1'b0;
      toTorque = 1'b0;
      if (slatMin) begin
         setCond = speedErr < 0;
         relCond = speedErr > setptExt;
         toSpeed = spdExt < trefExt || setCond;
         toTorque = spdExt > trefExt;
      end else if (slatMax) begin
         setCond = speedErr > 0;
         relCond = speedErr < setptExt;
         toSpeed = spdExt > trefExt || setCond;
         toTorque = spdExt < trefExt;
      end
   end

   // Release needs the dwell reached, zero dwell means at once
   assign dwellDone = dwellCnt_reg >= dwell_reg;

   // Dwell counter in samples, restarting on any failed comparison
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         dwellCnt_reg <= '0;
      end else if (!slatOn || !forced_reg || !relCond) begin
         dwellCnt_reg <= '0;
      end else if (dwellCnt_reg != '1) begin
         dwellCnt_reg <= dwellCnt_reg + 1'b1;
      end
   end

   // Forced-speed flag; setting wins over release
   always_comb begin
      forced_next = forced_reg;
      if (!slatOn) begin
         forced_next = 1'b0;
      end else if (setCond) begin
         forced_next = 1'b1;
      end else if (forced_reg && relCond && dwellDone) begin
         forced_next = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         forced_reg <= 1'b0;
      end else begin
         forced_reg <= forced_next;
      end
   end

   // Torque/speed control state
   always_comb begin
      state_next = state_reg;
      if (!slatOn) begin
         state_next = ST_TORQUE;
      end else begin
         case (state_reg)
            ST_TORQUE: begin
               if (toSpeed) begin
                  state_next = ST_SPEED;
               end
            end
            ST_SPEED: begin
               // Still forced blocks the return
               if (!forced_reg && !setCond && toTorque) begin
                  state_next = ST_TORQUE;
               end
            end
            default: state_next = ST_TORQUE;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_TORQUE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Preload pulse at takeover keeps the torque step smooth
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         preloadStrobe_reg <= 1'b0;
         preloadValue_reg <= '0;
      end else begin
         preloadStrobe_reg <= slatOn && state_reg == ST_TORQUE
            && toSpeed;
         if (slatOn && state_reg == ST_TORQUE && toSpeed) begin
            preloadValue_reg <= slatMin ? torqueCmd_reg : tref;
         end
      end
   end

   // ****************************************
   // Torque command selection
   // ****************************************
   assign sumFull = spdExt + trefExt;
   assign absSpd = spdExt < 0 ? -spdExt : spdExt;
   assign absTref = trefExt < 0 ? -trefExt : trefExt;

   // Mode decode; unknown codes command zero torque for safety
   always_comb begin
      case (modeSel_reg)
         `MODE_ZERO: cmdNext = '0;
         `MODE_SPEED: cmdNext = spdRegTorque;
         `MODE_TORQUE: cmdNext = tref;
         `MODE_MIN: begin
            cmdNext = spdExt < trefExt ? spdRegTorque : tref;
         end
         `MODE_MAX: begin
            cmdNext = spdExt > trefExt ? spdRegTorque : tref;
         end
         `MODE_SUM: cmdNext = satW(sumFull);
         `MODE_ABS_MIN: begin
            cmdNext = absSpd < absTref ? spdRegTorque : tref;
         end
         `MODE_LIM_MIN, `MODE_LIM_MAX: begin
            cmdNext = state_next == ST_SPEED ? spdRegTorque : tref;
         end
         default: cmdNext = '0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         torqueCmd_reg <= '0;
      end else begin
         torqueCmd_reg <= cmdNext;
      end
   end

   assign torqueCmd = torqueCmd_reg;
   assign preloadStrobe = preloadStrobe_reg;
   assign preloadValue = preloadValue_reg;
   assign speedActive = state_reg == ST_SPEED;
   assign forcedSpeed = forced_reg;

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   sequence sTakeover;
      slatOn && state_reg == ST_TORQUE && toSpeed;
   endsequence
   sequence sPreloaded;
      preloadStrobe && speedActive;
   endsequence

   AST_TORQUE_CMD: assert property (modeSel_reg == `MODE_TORQUE
      |=> torqueCmd == $past(tref))
      else $error("Torque mode command not the scaled reference");
   AST_MIN_PICK: assert property (modeSel_reg == `MODE_MIN
      |=> torqueCmd <= $past(spdRegTorque) && torqueCmd <= $past(tref))
      else $error("Min mode did not apply the smaller value");
   AST_MAX_PICK: assert property (modeSel_reg == `MODE_MAX
      |=> torqueCmd >= $past(spdRegTorque) && torqueCmd >= $past(tref))
      else $error("Max mode did not apply the larger value");
   AST_SUM_ADD: assert property (modeSel_reg == `MODE_SUM
      && sumFull[W] == sumFull[W-1]
      |=> torqueCmd == $past(spdRegTorque) + $past(tref))
      else $error("Sum mode command not the sum");
   AST_PRELOAD: assert property (sTakeover |=> sPreloaded)
      else $error("Takeover without preload pulse");
   AST_PRELOAD_MAX: assert property (sTakeover ##0 slatMax
      |=> preloadValue == $past(tref))
      else $error("Max takeover preload not the torque reference");
   AST_FORCE_MIN: assert property (slatMin && speedErr < 0
      |=> forcedSpeed && speedActive)
      else $error("Negative error did not force speed");
   AST_FORCED_HOLD: assert property (slatOn && speedActive
      && forcedSpeed ##1 slatOn |-> speedActive)
      else $error("Returned to torque while forced");
   AST_DWELL_HOLD: assert property (slatOn && forced_reg
      && !dwellDone |=> forcedSpeed)
      else $error("Forcing released before dwell elapsed");
   AST_DEFAULT_RELEASE: assert property (slatMin && forced_reg
      && dwell_reg == '0 && errSetpt_reg == '0 && speedErr > 0
      |=> !forcedSpeed)
      else $error("Default settings did not release at once");
   AST_RETURN_MIN: assert property (slatMin && speedActive
      && !forced_reg && !setCond && spdExt > trefExt
      |=> !speedActive)
      else $error("No return to torque in limited min");
endmodule

// *** ref_controller.sv ***
`timescale 1ns/10ps

module ref_controller (
   input wire logic clk,
   input wire logic rstn,
   input wire logic signed [15:0] fbkSet,
   input wire logic signed [15:0] errSet,
   input wire logic signed [15:0] regSet,
   output logic signed [15:0] speedRef,
   output logic signed [15:0] speedFbk,
   output logic signed [15:0] spdRegTorque
);
   // ****************************************
   // Reference generation
   // ****************************************
   // Speed reference rides a small offset on the feedback so the regulator
   // stays saturated: above it in limited min, below it in limited max
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         speedRef <= 16'h0000;
         speedFbk <= 16'h0000;
      end else begin
         speedFbk <= fbkSet;
         speedRef <= fbkSet + errSet;
      end
   end

   // Regulator torque output is a plain level, one sample late like a loop
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         spdRegTorque <= 16'h0000;
      end else begin
         spdRegTorque <= regSet;
      end
   end
endmodule

// *** tb_top.sv ***
`timescale 1ns/10ps
`include "torque_arbiter_cfg.svh"

`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin badCount++; \
   $display("[FAIL] %s exp %0h got %0h", n, e, g); end end

module tb_top;
   logic clk, rstn, psel, penable, pwrite, pready, pslverr, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic signed [15:0] speedRef, speedFbk, spdRegTorque, torqueCmd;
   logic signed [15:0] preloadValue, fbkSet, errSet, regSet;
   logic preloadStrobe, speedActive, forcedSpeed;
   int badCount = 0;
   int checked = 0;

   torque_speed_mode_arbiter u_torque_speed_mode_arbiter (.clk(clk),
      .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .speedRef(speedRef), .speedFbk(speedFbk),
      .spdRegTorque(spdRegTorque), .torqueCmd(torqueCmd),
      .preloadStrobe(preloadStrobe), .preloadValue(preloadValue),
      .speedActive(speedActive), .forcedSpeed(forcedSpeed));

   ref_controller u_ref_controller (.clk(clk), .rstn(rstn), .fbkSet(fbkSet),
      .errSet(errSet), .regSet(regSet), .speedRef(speedRef),
      .speedFbk(speedFbk), .spdRegTorque(spdRegTorque));

   // ****************************************
   // Bus and wait helpers
   // ****************************************
   // One APB transfer; the wait is open ended, the watchdog bounds it
   task apbXfer(input logic [7:0] a, input logic wr, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1; penable <= 1'b0; paddr <= a; pwrite <= wr; pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function logic pick(input int s);
      return (s == 0) ? preloadStrobe : (s == 1) ? forcedSpeed : speedActive;
   endfunction

   // Bounded wait for a status output to reach a level
   task waitFor(input int s, input logic v);
      int n;
      n = 0;
      while (pick(s) !== v && n < 10) begin
         @(posedge clk);
         #1;
         n++;
      end
      // A wait that runs out is a mismatch in its own right
      if (pick(s) !== v) begin
         badCount++;
         $display("[FAIL] waitFor exp %0h got %0h", v, pick(s));
      end
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task testRegs();
      logic [7:0] a [5];
      logic [31:0] e [5];
      a = '{`CFG_OFS_MODE, `CFG_OFS_PRI_DIV, `CFG_OFS_SEC_MULT,
            `CFG_OFS_SETPT, `CFG_OFS_DWELL};
      e = '{32'h00000001, 32'h00000001, 32'h00000001, 32'h00000000,
            32'h00000000};
      for (int i = 0; i < 5; i++) begin
         apbXfer(a[i], 1'b0, 32'h00000000);
         `CHK("resetValue", e[i], rd)
      end
      apbXfer(8'h2C, 1'b0, 32'h00000000);
      `CHK("unmappedErr", 1'b1, err)
      apbXfer(`CFG_OFS_STATUS, 1'b1, 32'h00000003);
      `CHK("roWriteErr", 1'b1, err)
   endtask

   // Zero divider acts as one, then scaled sum 100/3 + 5*(-2) + 7 = 30
   task testTorque();
      regSet <= 16'h0032;
      apbXfer(`CFG_OFS_MODE, 1'b1, 32'h00000002);
      apbXfer(`CFG_OFS_PRI_REF, 1'b1, 32'h00000064);
      apbXfer(`CFG_OFS_PRI_DIV, 1'b1, 32'h00000000);
      apbXfer(`CFG_OFS_SEC_MULT, 1'b1, 32'h00000000);
      repeat (3) @(posedge clk);
      #1;
      `CHK("zeroDiv", 16'h0064, torqueCmd)
      apbXfer(`CFG_OFS_PRI_DIV, 1'b1, 32'h00000003);
      apbXfer(`CFG_OFS_SEC_REF, 1'b1, 32'h00000005);
      apbXfer(`CFG_OFS_SEC_MULT, 1'b1, 32'h0000FFFE);
      apbXfer(`CFG_OFS_TRIM, 1'b1, 32'h00000007);
      repeat (3) @(posedge clk);
      #1;
      `CHK("torqueCmd", 16'h001E, torqueCmd)
      apbXfer(`CFG_OFS_TREF, 1'b0, 32'h00000000);
      `CHK("trefRead", 32'h0000001E, rd)
   endtask

   // Every plain mode except torque plus an unused code, regulator above and below
   task testArb();
      logic [3:0] m [7];
      logic [15:0] hi [7];
      logic [15:0] lo [7];
      m = '{`MODE_MIN, `MODE_MAX, `MODE_SUM, `MODE_SPEED, `MODE_ABS_MIN,
            `MODE_ZERO, 4'h9};
      hi = '{16'h001E, 16'h0032, 16'h0050, 16'h0032, 16'h001E, 16'h0000,
             16'h0000};
      lo = '{16'hFFEC, 16'h001E, 16'h000A, 16'hFFEC, 16'hFFEC, 16'h0000,
             16'h0000};
      for (int i = 0; i < 7; i++) begin
         apbXfer(`CFG_OFS_MODE, 1'b1, {28'h0000000, m[i]});
         regSet <= 16'h0032;
         repeat (3) @(posedge clk);
         #1;
         `CHK("arbHigh", hi[i], torqueCmd)
         regSet <= 16'hFFEC;
         repeat (3) @(posedge clk);
         #1;
         `CHK("arbLow", lo[i], torqueCmd)
      end
   endtask

   task testLimMin();
      apbXfer(`CFG_OFS_SETPT, 1'b1, 32'h00000005);
      apbXfer(`CFG_OFS_DWELL, 1'b1, 32'h00000003);
      regSet <= 16'h0064;
      apbXfer(`CFG_OFS_MODE, 1'b1, 32'h00000007);
      repeat (3) @(posedge clk);
      #1;
      `CHK("minTorque", 16'h001E, torqueCmd)
      `CHK("minState", 1'b0, speedActive)
      errSet <= 16'hFFFF;
      waitFor(0, 1'b1);
      `CHK("minPreload", 16'h001E, preloadValue)
      `CHK("minForced", 1'b1, forcedSpeed)
      @(posedge clk);
      #1;
      `CHK("minStrobe", 1'b0, preloadStrobe)
      `CHK("minSpdCmd", 16'h0064, torqueCmd)
      // A failed sample in mid dwell must restart the count
      errSet <= 16'h000A;
      repeat (3) @(posedge clk);
      errSet <= 16'h0002;
      @(posedge clk);
      errSet <= 16'h000A;
      repeat (3) @(posedge clk);
      #1;
      `CHK("dwellHold", 1'b1, forcedSpeed)
      `CHK("forcedKeeps", 1'b1, speedActive)
      waitFor(1, 1'b0);
      `CHK("dwellDone", 1'b0, forcedSpeed)
      waitFor(2, 1'b0);
      `CHK("minBack", 16'h001E, torqueCmd)
      // Regulator dropping under the reference also hands over
      regSet <= 16'h000A;
      waitFor(2, 1'b1);
      `CHK("minDrop", 1'b1, speedActive)
   endtask

   task testLimMax();
      // Speed reference drops just under feedback before the mode change
      errSet <= 16'hFFFF;
      apbXfer(`CFG_OFS_SETPT, 1'b1, 32'h00000000);
      apbXfer(`CFG_OFS_DWELL, 1'b1, 32'h00000000);
      regSet <= 16'hFF9C;
      apbXfer(`CFG_OFS_MODE, 1'b1, 32'h00000008);
      repeat (3) @(posedge clk);
      #1;
      `CHK("maxTorque", 16'h001E, torqueCmd)
      regSet <= 16'h0032;
      waitFor(0, 1'b1);
      `CHK("maxPreload", 16'h001E, preloadValue)
      `CHK("maxSpeed", 1'b1, speedActive)
      regSet <= 16'h000A;
      waitFor(2, 1'b0);
      `CHK("maxBack", 16'h001E, torqueCmd)
      errSet <= 16'h0001;
      waitFor(1, 1'b1);
      `CHK("maxForced", 1'b1, forcedSpeed)
      errSet <= 16'hFFFF;
      waitFor(1, 1'b0);
      `CHK("maxRelease", 1'b0, forcedSpeed)
   endtask

   // ****************************************
   // Run control
   // ****************************************
   task completeRun();
      $display("checks %0d mismatches %0d", checked, badCount);
      if (badCount == 0 && checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Whole run is under two hundred cycles; this leaves wide margin
   initial begin
      repeat (20000) @(posedge clk);
      badCount++;
      completeRun();
   end

   initial begin
      rstn = 1'b0;
      {psel, penable, pwrite} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h00000000;
      fbkSet = 16'h00C8;
      errSet = 16'h0001;
      regSet = 16'h0000;
      repeat (6) @(posedge clk);
      rstn <= 1'b1;
      testRegs();
      testTorque();
      testArb();
      testLimMin();
      testLimMax();
      completeRun();
   end
endmodule
